//--- core/ocd_pkg.sv
//////////////////////////////////////////////////////////////////////////////
// Purpose: Shared constants and types for the opcode fetch/decode core
// Assumes: One clock, program memory with one cycle read latency
// Notes:   Cycle figures are clocks of the system oscillator
//////////////////////////////////////////////////////////////////////////////
package ocd_pkg;

  localparam logic [15:0] RESET_PC        = 16'h0000;
  localparam logic [5:0]  CLK_PER_MC_SLOW = 6'h0C;   // Twelve-clock mode
  localparam logic [5:0]  CLK_PER_MC_FAST = 6'h06;   // Six-clock mode
  localparam logic [1:0]  MC_SHIFT_ONE    = 2'h0;
  localparam logic [1:0]  MC_SHIFT_TWO    = 2'h1;
  localparam logic [1:0]  MC_SHIFT_FOUR   = 2'h2;
  localparam logic [3:0]  BIT_RAM_BASE    = 4'h2;    // Bit area starts at byte 0x20
  localparam logic [7:0]  OPC_SJMP        = 8'h80;
  localparam logic [7:0]  OPC_PRODUCT     = 8'hA4;
  localparam logic [7:0]  OPC_QUOTIENT    = 8'h84;
  localparam logic [7:0]  OPC_MOV_DIR_IMM = 8'h75;
  localparam logic [7:0]  OPC_ORL_DIR_IMM = 8'h43;
  localparam logic [7:0]  OPC_ANL_DIR_IMM = 8'h53;
  localparam logic [7:0]  OPC_XRL_DIR_IMM = 8'h63;

  typedef enum logic [7:0] {
    ST_BOOT  = 8'h01,
    ST_FETCH = 8'h02,
    ST_OPC   = 8'h04,
    ST_DEC   = 8'h08,
    ST_OP1   = 8'h10,
    ST_OP2   = 8'h20,
    ST_DONE  = 8'h40,
    ST_EXEC  = 8'h80
  } ocd_state_t;

endpackage

//--- core/ocd_opcode_table.sv
//////////////////////////////////////////////////////////////////////////////
// Purpose: Registered length and machine-cycle lookup for every opcode
// Assumes: Opcode stable one cycle before the result is read
// Notes:   Unlisted codes fall to one byte, one machine cycle
//////////////////////////////////////////////////////////////////////////////
`timescale 1ns/1ps
module ocd_opcode_table (
  input  wire logic       clock,
  input  wire logic       rst_n,
  input  wire logic [7:0] opcode,
  output logic      [1:0] length,
  output logic      [1:0] mc_shift
);

  function automatic logic [1:0] len_of(input logic [7:0] op);
    if (op[3:0] == 4'h1) begin
      len_of = 2'h2;
    end else if (op inside {8'h02, 8'h12, 8'h10, 8'h20, 8'h30, 8'h43, 8'h53, 8'h63, 8'h75, 8'h85,
                            8'h90, 8'hD5, [8'hB4:8'hBF]}) begin
      len_of = 2'h3;
    end else if (op inside {8'h05, 8'h15, 8'h24, 8'h25, 8'h34, 8'h35, 8'h40, 8'h42, 8'h44, 8'h45,
                            8'h50, 8'h52, 8'h54, 8'h55, 8'h60, 8'h62, 8'h64, 8'h65, 8'h70, 8'h72,
                            8'h74, 8'h76, 8'h77, 8'h80, 8'h82, 8'h86, 8'h87, 8'h92, 8'h94, 8'h95,
                            8'hA0, 8'hA2, 8'hA6, 8'hA7, 8'hB0, 8'hB2, 8'hC0, 8'hC2, 8'hC5, 8'hD0, 8'hD2,
                            8'hE5, 8'hF5, [8'h78:8'h7F], [8'h88:8'h8F], [8'hA8:8'hAF],
                            [8'hD8:8'hDF]}) begin
      len_of = 2'h2;
    end else begin
      len_of = 2'h1;
    end
  endfunction

  function automatic logic [1:0] mc_of(input logic [7:0] op);
    if (op == ocd_pkg::OPC_PRODUCT || op == ocd_pkg::OPC_QUOTIENT) begin
      mc_of = ocd_pkg::MC_SHIFT_FOUR;
    end else if (op[3:0] == 4'h1 ||
                 op inside {8'h02, 8'h12, 8'h10, 8'h20, 8'h30, 8'h40, 8'h50, 8'h60, 8'h70, 8'h80,
                            8'h22, 8'h32, 8'h73, 8'h43, 8'h53, 8'h63, 8'h75, 8'h85, 8'h86, 8'h87,
                            8'h90, 8'h93, 8'h83, 8'hA3, 8'hA6, 8'hA7, 8'hC0, 8'hD0, 8'hD5, 8'h82,
                            8'hB0, 8'h72, 8'hA0, 8'h92, [8'h88:8'h8F], [8'hA8:8'hAF],
                            [8'hB4:8'hBF], [8'hD8:8'hDF], [8'hE0:8'hE3], [8'hF0:8'hF3]}) begin
      mc_of = ocd_pkg::MC_SHIFT_TWO;
    end else begin
      mc_of = ocd_pkg::MC_SHIFT_ONE;
    end
  endfunction

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      length   <= 2'h1;
      mc_shift <= ocd_pkg::MC_SHIFT_ONE;
    end else begin
      length   <= len_of(opcode);
      mc_shift <= mc_of(opcode);
    end
  end

endmodule // ocd_opcode_table

//--- core/ocd_core.sv
//////////////////////////////////////////////////////////////////////////////
// Purpose: Opcode fetch, operand fetch, operand addressing and cycle timing
// Assumes: pmem_data valid the cycle after pmem_rd is seen high
// Notes:   First operand byte is fetched speculatively; program reads are harmless
// Operation
// - Decode all standard family opcodes with their classic lengths and timings.
// - Each instruction begins by fetching one 8-bit opcode from program memory.
// - Opcode decides the operation and how many operand bytes follow.
// - Instructions are one, two or three bytes long.
// - Bank register operand picks one of eight registers in the current bank.
// - Direct address 0-127 is internal RAM, 128-255 is function register space.
// - Indirect operand uses register 0 or 1 as an 8-bit RAM pointer.
// - Immediates come from instruction bytes: 8-bit, or 16-bit for pointer load.
// - Long call and jump carry a full 16-bit target.
// - Absolute forms replace low 11 bits within the next instruction's 2k page.
// - Relative branches add signed 8-bit offset to next instruction address.
// - Bit operand addresses one bit in internal RAM or function register space.
// - Twelve-clock mode: 12, 24 or 48 clocks per instruction.
// - Six-clock mode: half of twelve-clock counts, 6, 12 or 24.
// - Configuration bit high selects twelve clocks, low selects six clocks.
//////////////////////////////////////////////////////////////////////////////
`timescale 1ns/1ps
module ocd_core (
  input  wire logic        clock,
  input  wire logic        rst_n,
  input  wire logic [7:0]  pmem_data,
  input  wire logic [1:0]  bank_select,
  input  wire logic        load_pc,
  input  wire logic [15:0] load_pc_value,
  input  wire logic        fast_cycle_config_bit,
  output logic             pmem_rd,
  output logic      [15:0] pmem_addr,
  output logic             insn_valid,
  output logic      [7:0]  insn_opcode,
  output logic      [15:0] insn_addr,
  output logic      [1:0]  insn_length,
  output logic      [15:0] insn_next_pc,
  output logic      [5:0]  insn_clocks,
  output logic             six_clock_cycle_mode,
  output logic      [7:0]  operand1,
  output logic      [7:0]  operand2,
  output logic             uses_bank_register,
  output logic      [2:0]  bank_work_register,
  output logic      [4:0]  bank_reg_ram_addr,
  output logic             uses_indirect,
  output logic             indirect_pointer_register,
  output logic      [4:0]  pointer_ram_addr,
  output logic      [7:0]  direct_addr,
  output logic             direct_is_sfr,
  output logic      [7:0]  bit_byte_addr,
  output logic      [2:0]  bit_index,
  output logic      [7:0]  imm8,
  output logic      [15:0] data_pointer_imm,
  output logic      [15:0] long_branch_target,
  output logic      [15:0] page_branch_target,
  output logic      [15:0] rel_branch_target
);

  ocd_pkg::ocd_state_t state;
  logic [15:0] pc;
  logic [15:0] start_pc;
  logic [7:0]  opcode;
  logic [7:0]  op1;
  logic [7:0]  op2;
  logic [5:0]  clk_cnt;
  logic [1:0]  tbl_len;
  logic [1:0]  tbl_shift;
  logic        cfg_meta;
  logic        cfg_sync;
  logic [7:0]  rel;
  logic        exec_end;
  logic [7:0]  tbl_opcode;

  // Table looks at the byte in flight so its answer is ready in decode
  assign tbl_opcode = (state == ocd_pkg::ST_OPC) ? pmem_data : opcode;
  assign rel      = (tbl_len == 2'h3) ? op2 : op1;
  assign exec_end = (state == ocd_pkg::ST_EXEC) && (clk_cnt == insn_clocks - 6'h01);

  ocd_opcode_table u_table (
    .clock    (clock),
    .rst_n    (rst_n),
    .opcode   (tbl_opcode),
    .length   (tbl_len),
    .mc_shift (tbl_shift)
  );

  //////////////////////////////////////////////////////////////////////////////
  // Mode pin comes from off-chip; two flops before use
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      cfg_meta <= 1'b1;
      cfg_sync <= 1'b1;
    end else begin
      cfg_meta <= fast_cycle_config_bit;
      cfg_sync <= cfg_meta;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Sequencer
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      state <= ocd_pkg::ST_BOOT;
    end else begin
      unique case (state)
        ocd_pkg::ST_BOOT:  state <= ocd_pkg::ST_FETCH;
        ocd_pkg::ST_FETCH: state <= ocd_pkg::ST_OPC;
        ocd_pkg::ST_OPC:   state <= ocd_pkg::ST_DEC;
        ocd_pkg::ST_DEC:   state <= (tbl_len == 2'h1) ? ocd_pkg::ST_DONE : ocd_pkg::ST_OP1;
        ocd_pkg::ST_OP1:   state <= (tbl_len == 2'h3) ? ocd_pkg::ST_OP2 : ocd_pkg::ST_DONE;
        ocd_pkg::ST_OP2:   state <= ocd_pkg::ST_DONE;
        ocd_pkg::ST_DONE:  state <= ocd_pkg::ST_EXEC;
        ocd_pkg::ST_EXEC:  state <= exec_end ? ocd_pkg::ST_FETCH : ocd_pkg::ST_EXEC;
      endcase
    end
  end

  // Cycle index within the instruction, zero in the fetch cycle
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      clk_cnt <= 6'h00;
    end else if (state == ocd_pkg::ST_BOOT || exec_end) begin
      clk_cnt <= 6'h00;
    end else begin
      clk_cnt <= clk_cnt + 6'h01;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Program counter and byte capture
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      pc       <= ocd_pkg::RESET_PC;
      start_pc <= ocd_pkg::RESET_PC;
      opcode   <= 8'h00;
      op1      <= 8'h00;
      op2      <= 8'h00;
    end else begin
      if (state == ocd_pkg::ST_FETCH) begin
        start_pc <= pc;
      end
      if (state == ocd_pkg::ST_OPC) begin
        opcode <= pmem_data;
        pc     <= pc + 16'h0001;
      end else if (state == ocd_pkg::ST_OP1) begin
        op1 <= pmem_data;
        pc  <= pc + 16'h0001;
      end else if (state == ocd_pkg::ST_OP2) begin
        op2 <= pmem_data;
        pc  <= pc + 16'h0001;
      end else if (state == ocd_pkg::ST_EXEC && load_pc) begin
        pc <= load_pc_value;
      end
    end
  end

  // Reads are issued a cycle ahead so data lands in the capture state
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      pmem_rd   <= 1'b0;
      pmem_addr <= ocd_pkg::RESET_PC;
    end else begin
      pmem_rd <= 1'b0;
      if (state == ocd_pkg::ST_BOOT || exec_end) begin
        pmem_rd   <= 1'b1;
        pmem_addr <= (state == ocd_pkg::ST_EXEC && load_pc) ? load_pc_value : pc;
      end else if (state == ocd_pkg::ST_OPC) begin
        pmem_rd   <= 1'b1;
        pmem_addr <= pc + 16'h0001;
      end else if (state == ocd_pkg::ST_DEC && tbl_len == 2'h3) begin
        pmem_rd   <= 1'b1;
        pmem_addr <= pc + 16'h0001;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Decoded results, loaded once per instruction
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      insn_valid                <= 1'b0;
      insn_opcode               <= 8'h00;
      insn_addr                 <= ocd_pkg::RESET_PC;
      insn_length               <= 2'h1;
      insn_next_pc              <= ocd_pkg::RESET_PC;
      insn_clocks               <= ocd_pkg::CLK_PER_MC_SLOW;
      six_clock_cycle_mode      <= 1'b0;
      operand1                  <= 8'h00;
      operand2                  <= 8'h00;
      uses_bank_register        <= 1'b0;
      bank_work_register        <= 3'h0;
      bank_reg_ram_addr         <= 5'h00;
      uses_indirect             <= 1'b0;
      indirect_pointer_register <= 1'b0;
      pointer_ram_addr          <= 5'h00;
      direct_addr               <= 8'h00;
      direct_is_sfr             <= 1'b0;
      bit_byte_addr             <= 8'h00;
      bit_index                 <= 3'h0;
      imm8                      <= 8'h00;
      data_pointer_imm          <= 16'h0000;
      long_branch_target        <= 16'h0000;
      page_branch_target        <= 16'h0000;
      rel_branch_target         <= 16'h0000;
    end else begin
      insn_valid <= (state == ocd_pkg::ST_DONE);
      if (state == ocd_pkg::ST_DONE) begin
        insn_opcode          <= opcode;
        insn_addr            <= start_pc;
        insn_length          <= tbl_len;
        insn_next_pc         <= pc;
        // Mode sampled per instruction so a pin change never splits one
        six_clock_cycle_mode <= !cfg_sync;
        insn_clocks          <= (cfg_sync ? ocd_pkg::CLK_PER_MC_SLOW
                                          : ocd_pkg::CLK_PER_MC_FAST) << tbl_shift;
        operand1             <= op1;
        operand2             <= op2;
        uses_bank_register   <= opcode[3];
        bank_work_register   <= opcode[2:0];
        bank_reg_ram_addr    <= {bank_select, opcode[2:0]};
        uses_indirect        <= (opcode[3:1] == 3'h3) || (opcode[7:5] == 3'h7 && opcode[3:1] == 3'h1);
        indirect_pointer_register <= opcode[0];
        pointer_ram_addr     <= {bank_select, 2'h0, opcode[0]};
        direct_addr          <= op1;
        direct_is_sfr        <= op1[7];
        bit_byte_addr        <= op1[7] ? {op1[7:3], 3'h0}
                                       : {ocd_pkg::BIT_RAM_BASE, op1[6:3]};
        bit_index            <= op1[2:0];
        imm8                 <= (opcode inside {ocd_pkg::OPC_MOV_DIR_IMM, ocd_pkg::OPC_ORL_DIR_IMM,
                                                ocd_pkg::OPC_ANL_DIR_IMM, ocd_pkg::OPC_XRL_DIR_IMM})
                                ? op2 : op1;
        data_pointer_imm     <= {op1, op2};
        long_branch_target   <= {op1, op2};
        page_branch_target   <= {pc[15:11], opcode[7:5], op1};
        rel_branch_target    <= pc + {{8{rel[7]}}, rel};
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Checks; period counter is helper logic only
  logic [5:0] per_cnt;
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      per_cnt <= 6'h00;
    end else begin
      per_cnt <= (state == ocd_pkg::ST_FETCH) ? 6'h01 : per_cnt + 6'h01;
    end
  end

  sequence s_opcode_then_operand;
    pmem_rd ##1 !pmem_rd ##1 pmem_rd;
  endsequence

  property p_opcode_fetch;
    @(posedge clock) disable iff (!rst_n) state == ocd_pkg::ST_FETCH |-> s_opcode_then_operand;
  endproperty
  a_opcode_fetch: assert property (p_opcode_fetch) else $error("opcode read not issued");

  property p_decode_bound;
    @(posedge clock) disable iff (!rst_n) state == ocd_pkg::ST_FETCH |-> ##[4:6] insn_valid;
  endproperty
  a_decode_bound: assert property (p_decode_bound) else $error("decode result late");

  property p_length;
    @(posedge clock) disable iff (!rst_n)
      insn_valid |-> insn_length != 2'h0 && insn_next_pc == insn_addr + {14'h0000, insn_length};
  endproperty
  a_length: assert property (p_length) else $error("length and pc step disagree");

  property p_period;
    @(posedge clock) disable iff (!rst_n)
      (state == ocd_pkg::ST_FETCH && $past(state) == ocd_pkg::ST_EXEC) |->
        $past(per_cnt) == insn_clocks - 6'h01;
  endproperty
  a_period: assert property (p_period) else $error("instruction period wrong");

  property p_twelve;
    @(posedge clock) disable iff (!rst_n)
      insn_valid && !six_clock_cycle_mode |-> insn_clocks inside {6'h0C, 6'h18, 6'h30};
  endproperty
  a_twelve: assert property (p_twelve) else $error("bad twelve-clock count");

  property p_six;
    @(posedge clock) disable iff (!rst_n)
      insn_valid && (insn_opcode == ocd_pkg::OPC_PRODUCT) |-> insn_clocks == (six_clock_cycle_mode ? 6'h18 : 6'h30);
  endproperty
  a_six: assert property (p_six) else $error("bad multiply count");

  property p_rel;
    @(posedge clock) disable iff (!rst_n)
      insn_valid && insn_opcode == ocd_pkg::OPC_SJMP |->
        rel_branch_target == insn_next_pc + {{8{operand1[7]}}, operand1};
  endproperty
  a_rel: assert property (p_rel) else $error("relative target wrong");

  property p_page;
    @(posedge clock) disable iff (!rst_n)
      insn_valid && insn_opcode[3:0] == 4'h1 |-> page_branch_target[15:11] == insn_next_pc[15:11];
  endproperty
  a_page: assert property (p_page) else $error("page target left page");

  property p_direct;
    @(posedge clock) disable iff (!rst_n) insn_valid |-> direct_is_sfr == (direct_addr >= 8'h80);
  endproperty
  a_direct: assert property (p_direct) else $error("direct space wrong");

  property p_bank;
    @(posedge clock) disable iff (!rst_n)
      insn_valid && uses_bank_register |-> bank_reg_ram_addr[2:0] == insn_opcode[2:0];
  endproperty
  a_bank: assert property (p_bank) else $error("bank register select wrong");

endmodule // ocd_core

//--- bench/ocd_pmem_model.sv
// Purpose: Program memory model facing the fetch/decode core
// Assumes: One cycle read latency, no wait states
// Notes:   Bench fills mem by hierarchy; unread cycles show a toggling byte
////////////////////////////////////////
`timescale 1ns/1ps
module ocd_pmem_model (
  input  wire logic        clock,
  input  wire logic        rst_n,
  input  wire logic        pmem_rd,
  input  wire logic [15:0] pmem_addr,
  output logic      [7:0]  pmem_data
);
  logic [7:0] mem [0:65535];

  initial begin
    for (int i = 0; i < 65536; i++) begin
      mem[i] = 8'h00;
    end
  end

  // Toggle outside the capture cycle so a late or early capture is seen
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      pmem_data <= 8'hA5;
    end else if (pmem_rd) begin
      pmem_data <= mem[pmem_addr];
    end else begin
      pmem_data <= ~pmem_data;
    end
  end
endmodule // ocd_pmem_model

//--- bench/tb_top.sv
// Purpose: Self-checking bench for the opcode fetch/decode core
// Assumes: Mode pin static around reset
// Notes:   Table runs in both cycle modes, then branch and reset cases
////////////////////////////////////////
`timescale 1ns/1ps
`define CHK(got, exp) begin comparisons++; if ((got) !== (exp)) begin n_mismatch++; \
  $display("[FAIL] t=%0t got=%0h exp=%0h", $time, (got), (exp)); end end
module tb_top;
  typedef struct {logic [7:0] opc; logic [7:0] op1; logic [7:0] op2; logic [1:0] len; logic [5:0] clk12;} ocd_row_t;
  localparam int N_ROWS = 30;
  logic        clock, rst_n, load_pc, fast_cycle_config_bit, pmem_rd, insn_valid, six_clock_cycle_mode;
  logic        uses_bank_register, uses_indirect, indirect_pointer_register, direct_is_sfr;
  logic [1:0]  bank_select, insn_length, cur_bank;
  logic [2:0]  bank_work_register, bit_index;
  logic [4:0]  bank_reg_ram_addr, pointer_ram_addr;
  logic [5:0]  insn_clocks;
  logic [7:0]  pmem_data, insn_opcode, operand1, operand2, direct_addr, bit_byte_addr, imm8;
  logic [15:0] load_pc_value, pmem_addr, insn_addr, insn_next_pc, data_pointer_imm;
  logic [15:0] long_branch_target, page_branch_target, rel_branch_target, pc;
  int          n_mismatch, comparisons, prev_clk, prev_len;
  ocd_row_t    jrows [2] = '{'{8'hE1, 8'h3C, 8'h80, 2'h2, 6'h18}, '{8'h80, 8'h80, 8'h00, 2'h2, 6'h18}};
  ocd_row_t    rows [N_ROWS] = '{
    '{8'h00, 8'h00, 8'h00, 2'h1, 6'h0C}, '{8'h2D, 8'h00, 8'h00, 2'h1, 6'h0C},
    '{8'h27, 8'h00, 8'h00, 2'h1, 6'h0C}, '{8'h25, 8'h7F, 8'h00, 2'h2, 6'h0C},
    '{8'h24, 8'h80, 8'h00, 2'h2, 6'h0C}, '{8'hA3, 8'h00, 8'h00, 2'h1, 6'h18},
    '{8'hA4, 8'h00, 8'h00, 2'h1, 6'h30}, '{8'h84, 8'h00, 8'h00, 2'h1, 6'h30},
    '{8'h53, 8'h80, 8'h5A, 2'h3, 6'h18}, '{8'h43, 8'h2F, 8'hC3, 2'h3, 6'h18},
    '{8'h63, 8'hFF, 8'h01, 2'h3, 6'h18}, '{8'h75, 8'h00, 8'hA5, 2'h3, 6'h18},
    '{8'h90, 8'h12, 8'h34, 2'h3, 6'h18}, '{8'h12, 8'hAB, 8'hCD, 2'h3, 6'h18},
    '{8'h02, 8'hFF, 8'hFE, 2'h3, 6'h18}, '{8'h11, 8'h55, 8'h00, 2'h2, 6'h18},
    '{8'hF1, 8'hFF, 8'h00, 2'h2, 6'h18}, '{8'hE1, 8'h00, 8'h00, 2'h2, 6'h18},
    '{8'h80, 8'hFE, 8'h00, 2'h2, 6'h18}, '{8'h60, 8'h7F, 8'h00, 2'h2, 6'h18},
    '{8'h70, 8'h80, 8'h00, 2'h2, 6'h18}, '{8'hC2, 8'h2F, 8'h00, 2'h2, 6'h0C},
    '{8'hD2, 8'h8B, 8'h00, 2'h2, 6'h0C}, '{8'hE2, 8'h00, 8'h00, 2'h1, 6'h18},
    '{8'hF3, 8'h00, 8'h00, 2'h1, 6'h18}, '{8'h85, 8'h90, 8'h07, 2'h3, 6'h18},
    '{8'hF8, 8'h00, 8'h00, 2'h1, 6'h0C}, '{8'hE5, 8'hFF, 8'h00, 2'h2, 6'h0C},
    '{8'hD7, 8'h00, 8'h00, 2'h1, 6'h0C}, '{8'hA8, 8'h20, 8'h00, 2'h2, 6'h18}};

  ocd_pmem_model i_pmem (.clock, .rst_n, .pmem_rd, .pmem_addr, .pmem_data);

  ocd_core i_dut (.clock, .rst_n, .pmem_data, .bank_select, .load_pc, .load_pc_value, .fast_cycle_config_bit,
    .pmem_rd, .pmem_addr, .insn_valid, .insn_opcode, .insn_addr, .insn_length, .insn_next_pc, .insn_clocks,
    .six_clock_cycle_mode, .operand1, .operand2, .uses_bank_register, .bank_work_register, .bank_reg_ram_addr,
    .uses_indirect, .indirect_pointer_register, .pointer_ram_addr, .direct_addr, .direct_is_sfr, .bit_byte_addr,
    .bit_index, .imm8, .data_pointer_imm, .long_branch_target, .page_branch_target, .rel_branch_target);

  always #50 clock = ~clock;

  ////////////////////////////////////////
  task automatic print_verdict();
    if (n_mismatch == 0 && comparisons > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  task automatic wait_valid(output int cycles);
    cycles = 0;
    do begin
      @(posedge clock);
      #1;
      cycles++;
    end while (insn_valid !== 1'b1 && cycles < 300);
    if (insn_valid !== 1'b1) begin
      n_mismatch++;
      print_verdict();
    end
  endtask

  task automatic place(input logic [15:0] a, input ocd_row_t r);
    i_pmem.mem[a] = r.opc;
    i_pmem.mem[a + 16'h0001] = r.op1;
    i_pmem.mem[a + 16'h0002] = r.op2;
  endtask

  task automatic do_reset();
    rst_n = 1'b0;
    cur_bank = 2'h0;
    bank_select = 2'h0;
    prev_clk = 0;
    repeat (16) @(posedge clock);
    #1;
    `CHK(pmem_rd, 1'b0)
    `CHK(insn_valid, 1'b0)
    `CHK(insn_clocks, ocd_pkg::CLK_PER_MC_SLOW)
    rst_n = 1'b1;
    @(posedge clock);
    #1;
    `CHK(pmem_rd, 1'b1)
    `CHK(pmem_addr, ocd_pkg::RESET_PC)
  endtask

  // Fetch-to-fetch spacing is the cycle count; valid lags fetch by 3 + length
  task automatic check_insn(input ocd_row_t r, input logic [15:0] a, input logic six);
    logic [15:0] nxt;
    logic [7:0]  rel;
    logic [5:0]  clk;
    int          gap;
    nxt = a + {14'h0000, r.len};
    rel = (r.len == 2'h3) ? r.op2 : r.op1;
    clk = six ? (r.clk12 >> 1) : r.clk12;
    wait_valid(gap);
    if (prev_clk != 0) `CHK(gap, prev_clk + int'(r.len) - prev_len)
    `CHK(insn_opcode, r.opc)
    `CHK(insn_addr, a)
    `CHK(insn_length, r.len)
    `CHK(insn_next_pc, nxt)
    `CHK(insn_clocks, clk)
    `CHK(six_clock_cycle_mode, six)
    `CHK(uses_bank_register, r.opc[3])
    if (r.opc[3]) begin
      `CHK(bank_work_register, r.opc[2:0])
      `CHK(bank_reg_ram_addr, {cur_bank, r.opc[2:0]})
    end
    `CHK(uses_indirect, (r.opc[3:1] == 3'h3) || (r.opc[7:5] == 3'h7 && r.opc[3:1] == 3'h1))
    if ((r.opc[3:1] == 3'h3) || (r.opc[7:5] == 3'h7 && r.opc[3:1] == 3'h1)) begin
      `CHK(indirect_pointer_register, r.opc[0])
      `CHK(pointer_ram_addr, {cur_bank, 2'h0, r.opc[0]})
    end
    if (r.len != 2'h1) begin
      `CHK(operand1, r.op1)
      `CHK(direct_addr, r.op1)
      `CHK(direct_is_sfr, r.op1[7])
      `CHK(bit_byte_addr, r.op1[7] ? (r.op1 & 8'hF8) : (8'h20 + {4'h0, r.op1[6:3]}))
      `CHK(bit_index, r.op1[2:0])
      `CHK(imm8, (r.opc inside {8'h75, 8'h43, 8'h53, 8'h63}) ? r.op2 : r.op1)
      `CHK(page_branch_target, {nxt[15:11], r.opc[7:5], r.op1})
      `CHK(rel_branch_target, nxt + {{8{rel[7]}}, rel})
    end
    if (r.len == 2'h3) begin
      `CHK(operand2, r.op2)
      `CHK(data_pointer_imm, {r.op1, r.op2})
      `CHK(long_branch_target, {r.op1, r.op2})
    end
    prev_clk = clk;
    prev_len = r.len;
  endtask

  task automatic run_table(input logic six);
    pc = 16'h0000;
    for (int i = 0; i < N_ROWS; i++) begin
      check_insn(rows[i], pc, six);
      pc = pc + {14'h0000, rows[i].len};
      cur_bank = cur_bank + 2'h1;
      bank_select = cur_bank;
    end
  endtask

  // Branch hook costs one edge here, so the next spacing is one short
  task automatic branch_to(input logic [15:0] v);
    load_pc = 1'b1;
    load_pc_value = v;
    @(posedge clock);
    #1;
    load_pc = 1'b0;
    prev_clk--;
  endtask

  ////////////////////////////////////////
  initial begin
    clock = 1'b0;
    rst_n = 1'b0;
    load_pc = 1'b0;
    load_pc_value = 16'h0000;
    fast_cycle_config_bit = 1'b1;
    bank_select = 2'h0;
    n_mismatch = 0;
    comparisons = 0;
    prev_len = 0;
    #1;
    pc = 16'h0000;
    for (int i = 0; i < N_ROWS; i++) begin
      place(pc, rows[i]);
      pc = pc + {14'h0000, rows[i].len};
    end
    place(16'h07FE, jrows[0]);
    place(16'h0800, jrows[1]);
    do_reset();
    run_table(1'b0);
    fast_cycle_config_bit = 1'b0;
    branch_to(16'h0000);
    run_table(1'b1);
    // Page target taken from the next page, not the opcode's own
    branch_to(16'h07FE);
    check_insn(jrows[0], 16'h07FE, 1'b1);
    check_insn(jrows[1], 16'h0800, 1'b1);
    fast_cycle_config_bit = 1'b1;
    do_reset();
    check_insn(rows[0], 16'h0000, 1'b0);
    print_verdict();
  end
endmodule // tb_top
